// >>> hw/xpc_pkg.sv
// Shared constants and types for the crosspoint latch host controller.
package xpc_pkg;

   // Core clock period and host-side pin timing, in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SETUP_NS = 40;
   localparam int unsigned PULSE_NS = 80;
   localparam int unsigned HOLD_NS = 40;
   localparam int unsigned ACCESS_NS = 120;
   localparam int unsigned BREAK_MAKE_NS = 10;
   localparam int unsigned SYNC_STAGES = 2;

   // A least time rounded up to whole cycles, never below one.
   function automatic int unsigned min_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction

   // Counter load values: phase length in cycles minus one.
   localparam logic [7:0] SETUP_LD = 8'(min_cyc(SETUP_NS) - 1);
   localparam logic [7:0] PULSE_LD = 8'(min_cyc(PULSE_NS) - 1);
   localparam logic [7:0] HOLD_LD = 8'(min_cyc(HOLD_NS) - 1);
   localparam logic [7:0] SETTLE_LD = 8'(min_cyc(HOLD_NS) + min_cyc(BREAK_MAKE_NS) - 1);
   localparam logic [7:0] READ_LD = 8'(min_cyc(ACCESS_NS) + SYNC_STAGES - 1);

   // Host commands.
   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,
      OP_DIRECT = 3'h1,
      OP_COMMIT = 3'h2,
      OP_READ = 3'h3,
      OP_CLEAR = 3'h4
   } xpc_op_e;

   // Sequencer phases.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SETUP = 2'h1,
      ST_PULSE = 2'h2,
      ST_HOLD = 2'h3
   } xpc_state_e;

   typedef struct packed {
      xpc_op_e op;
      logic [1:0] x_line_addr;
      logic [2:0] y_line_addr;
      logic data;
   } xpc_cmd_s;

   typedef struct packed {
      logic cs_n;
      logic rw;
      logic [1:0] x_line_addr;
      logic [2:0] y_line_addr;
      logic data_out;
      logic data_oe;
      logic first_stage_load_n;
      logic second_stage_transfer_n;
      logic latch_clear_n;
   } xpc_pins_s;

   // Quiet bus: deselected, read direction, data released, strobes and clear inactive.
   localparam xpc_pins_s PINS_IDLE = '{cs_n: 1'b1, rw: 1'b1, x_line_addr: 2'h0,
      y_line_addr: 3'h0, data_out: 1'b0, data_oe: 1'b0, first_stage_load_n: 1'b1,
      second_stage_transfer_n: 1'b1, latch_clear_n: 1'b1};

endpackage

// >>> hw/xpc_host.sv
// Host-side sequencer that drives the crosspoint latch pins from a command port.
// Summary of operation
// - Written data 1 closes the node, 0 opens it.
// - Write: select and read/write low, clear high, pulse first-stage strobe.
// - Direct update: hold first-stage strobe low and pulse second-stage strobe.
// - Batch update: write with second strobe high, then pulse it once.
module xpc_host (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_valid,
   input xpc_pkg::xpc_cmd_s i_cmd,
   output logic o_cmd_ready,
   output logic o_rd_valid,
   output logic o_rd_data,
   input wire logic i_data_in,
   output xpc_pkg::xpc_pins_s o_pins
);

   xpc_pkg::xpc_state_e state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   xpc_pkg::xpc_cmd_s cmd_r, cmd_nxt;
   xpc_pkg::xpc_pins_s pins_r, pins_nxt;
   logic ready_r, ready_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic rd_data_r, rd_data_nxt;
   logic data_meta_r, data_sync_r;

   // The data pin comes from another chip, so it passes two flops before use.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         data_meta_r <= 1'b0;
         data_sync_r <= 1'b0;
      end else begin
         data_meta_r <= i_data_in;
         data_sync_r <= data_meta_r;
      end
   end

   // Sequencer: setup, strobe pulse (or read access wait), hold, then back to idle.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cmd_nxt = cmd_r;
      pins_nxt = pins_r;
      ready_nxt = ready_r;
      rd_valid_nxt = 1'b0;
      rd_data_nxt = rd_data_r;
      unique case (state_r)
         xpc_pkg::ST_IDLE: begin
            if (i_cmd_valid && ready_r) begin
               cmd_nxt = i_cmd;
               ready_nxt = 1'b0;
               state_nxt = xpc_pkg::ST_SETUP;
               cnt_nxt = xpc_pkg::SETUP_LD;
               pins_nxt = xpc_pkg::PINS_IDLE;
               pins_nxt.x_line_addr = i_cmd.x_line_addr;
               pins_nxt.y_line_addr = i_cmd.y_line_addr;
               if (i_cmd.op == xpc_pkg::OP_WRITE || i_cmd.op == xpc_pkg::OP_DIRECT) begin
                  // Turn the bus round to write before any strobe moves.
                  pins_nxt.cs_n = 1'b0;
                  pins_nxt.rw = 1'b0;
                  pins_nxt.data_out = i_cmd.data;
                  pins_nxt.data_oe = 1'b1;
               end else if (i_cmd.op == xpc_pkg::OP_READ) begin
                  pins_nxt.cs_n = 1'b0;
                  pins_nxt.rw = 1'b1;
               end
            end
         end
         xpc_pkg::ST_SETUP: begin
            if (cnt_r == 8'h00) begin
               state_nxt = xpc_pkg::ST_PULSE;
               cnt_nxt = (cmd_r.op == xpc_pkg::OP_READ) ? xpc_pkg::READ_LD : xpc_pkg::PULSE_LD;
               unique case (cmd_r.op)
                  xpc_pkg::OP_WRITE: pins_nxt.first_stage_load_n = 1'b0;
                  xpc_pkg::OP_DIRECT: begin
                     // Both stages transparent, so the node follows the data pin.
                     pins_nxt.first_stage_load_n = 1'b0;
                     pins_nxt.second_stage_transfer_n = 1'b0;
                  end
                  xpc_pkg::OP_COMMIT: pins_nxt.second_stage_transfer_n = 1'b0;
                  xpc_pkg::OP_CLEAR: pins_nxt.latch_clear_n = 1'b0;
                  default: pins_nxt.first_stage_load_n = 1'b1;
               endcase
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         xpc_pkg::ST_PULSE: begin
            if (cnt_r == 8'h00) begin
               // Address and data stay put past the rising edge so the latch freezes them.
               pins_nxt.first_stage_load_n = 1'b1;
               pins_nxt.second_stage_transfer_n = 1'b1;
               pins_nxt.latch_clear_n = 1'b1;
               state_nxt = xpc_pkg::ST_HOLD;
               // A commit gets extra settle time to cover the break-before-make gap; a direct update does not.
               cnt_nxt = (cmd_r.op == xpc_pkg::OP_COMMIT) ? xpc_pkg::SETTLE_LD
                  : xpc_pkg::HOLD_LD;
               if (cmd_r.op == xpc_pkg::OP_READ) begin
                  rd_data_nxt = data_sync_r;
                  rd_valid_nxt = 1'b1;
               end
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         xpc_pkg::ST_HOLD: begin
            if (cnt_r == 8'h00) begin
               pins_nxt = xpc_pkg::PINS_IDLE;
               ready_nxt = 1'b1;
               state_nxt = xpc_pkg::ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
      endcase
   end

   // Sequencer registers; the pins come straight from flops to avoid glitching strobes.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= xpc_pkg::ST_IDLE;
         cnt_r <= 8'h00;
         cmd_r <= '0;
         pins_r <= xpc_pkg::PINS_IDLE;
         ready_r <= 1'b1;
         rd_valid_r <= 1'b0;
         rd_data_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cmd_r <= cmd_nxt;
         pins_r <= pins_nxt;
         ready_r <= ready_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // Outputs are the registers themselves.
   assign o_pins = pins_r;
   assign o_cmd_ready = ready_r;
   assign o_rd_valid = rd_valid_r;
   assign o_rd_data = rd_data_r;

   // Checks on the pin sequences this controller produces.
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence load_low_s;
      !pins_r.first_stage_load_n [*2];
   endsequence

   sequence transfer_low_s;
      !pins_r.second_stage_transfer_n [*2];
   endsequence

   load_width_a: assert property (
      $fell(pins_r.first_stage_load_n) |-> load_low_s ##1 pins_r.first_stage_load_n)
      else $error("First-stage strobe pulse has the wrong width.");

   write_setup_a: assert property (
      $fell(pins_r.first_stage_load_n) |->
         !pins_r.cs_n && !pins_r.rw && pins_r.latch_clear_n && pins_r.data_oe)
      else $error("First-stage strobe fell outside a selected write.");

   load_hold_a: assert property (
      $rose(pins_r.first_stage_load_n) |->
         !pins_r.cs_n && $stable(pins_r.data_out) && $stable(pins_r.x_line_addr)
         && $stable(pins_r.y_line_addr))
      else $error("Data or address moved at the first-stage strobe rising edge.");

   commit_width_a: assert property (
      ($fell(pins_r.second_stage_transfer_n) && pins_r.first_stage_load_n) |->
         transfer_low_s ##1 pins_r.second_stage_transfer_n)
      else $error("Second-stage strobe pulse has the wrong width.");

   commit_settle_a: assert property (
      ($rose(pins_r.second_stage_transfer_n) && $past(pins_r.first_stage_load_n)) |->
         !o_cmd_ready [*2] ##1 o_cmd_ready)
      else $error("Transfer settle time was not kept.");

   direct_both_a: assert property (
      ($fell(pins_r.second_stage_transfer_n) && !pins_r.first_stage_load_n) |->
         $fell(pins_r.first_stage_load_n) && !pins_r.cs_n && !pins_r.rw)
      else $error("Direct update did not lower both strobes together.");

   clear_pulse_a: assert property (
      $fell(pins_r.latch_clear_n) |->
         (!pins_r.latch_clear_n && pins_r.cs_n) [*2] ##1 pins_r.latch_clear_n)
      else $error("Clear pulse has the wrong shape.");

   read_nostrobe_a: assert property (
      (!pins_r.cs_n && pins_r.rw) |-> pins_r.first_stage_load_n)
      else $error("First-stage strobe moved during a read.");

   read_release_a: assert property (
      pins_r.rw |-> !pins_r.data_oe)
      else $error("Host drove the data pin while reading.");

   read_result_a: assert property (
      o_rd_valid |-> !pins_r.cs_n && pins_r.rw && !$past(pins_r.cs_n, 5))
      else $error("Read result given outside a full read access.");

endmodule // xpc_host

// >>> dv/xpc_dev_model.sv
// Behavioural model of the crosspoint latch device as seen from its pins.
module xpc_dev_model (
   input xpc_pkg::xpc_pins_s i_pins,
   output logic o_wire,
   output logic [31:0] o_nodes
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] s1_r;
   logic [31:0] s1_late;
   logic late_xfer;
   logic dev_oe;
   logic last_v = 1'b0;
   logic [4:0] idx;

   // Node index and pin direction.
   assign idx = {i_pins.x_line_addr, i_pins.y_line_addr};
   assign dev_oe = !i_pins.cs_n && i_pins.rw;
   // A released pin shows the inverse of its last level, so a missed drive never matches.
   assign o_wire = i_pins.data_oe ? i_pins.data_out : dev_oe ? o_nodes[idx] : ~last_v;
   always @(o_wire) if (i_pins.data_oe || dev_oe) last_v = o_wire;

   // First stage: clear wins; a selected write with the strobe low is transparent.
   always @* begin
      if (!i_pins.latch_clear_n) s1_r = '0;
      else if (!i_pins.cs_n && !i_pins.rw && !i_pins.first_stage_load_n) s1_r[idx] = o_wire;
   end

   // Second stage: openings land at once, closings only after the break-to-make gap.
   assign #10 late_xfer = !i_pins.second_stage_transfer_n;
   assign #10 s1_late = s1_r;
   always @* begin
      if (!i_pins.latch_clear_n) o_nodes = '0;
      else if (!i_pins.second_stage_transfer_n)
         o_nodes = late_xfer ? (s1_r & s1_late) : (s1_r & o_nodes);
   end
endmodule // xpc_dev_model

// >>> dv/tb_xpc_host.sv
// Self-checking bench for the crosspoint latch host sequencer.
module tb_xpc_host;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk;
   logic nrst;
   logic cmd_valid;
   xpc_pkg::xpc_cmd_s cmd;
   logic cmd_ready;
   logic rd_valid;
   logic rd_data;
   logic dio;
   logic [31:0] nodes;
   xpc_pkg::xpc_pins_s pins;
   logic [31:0] exp1;
   logic [31:0] exp2;
   int bad_count;
   int checks_done;

   xpc_host i_xpc_host (.i_core_clk(clk), .i_nrst(nrst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
      .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_data_in(dio),
      .o_pins(pins));
   xpc_dev_model i_xpc_dev_model (.i_pins(pins), .o_wire(dio), .o_nodes(nodes));

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Issues one command, waits a bounded time for ready and judges the outcome.
   task automatic send(input xpc_pkg::xpc_op_e op, input logic [4:0] n, input logic d);
      int k;
      int lat;
      logic got;
      lat = (op == xpc_pkg::OP_COMMIT) ? 5 : (op == xpc_pkg::OP_READ) ? 7 : 4;
      got = 1'bx;
      @(posedge clk);
      #1 cmd_valid = 1'b1;
      cmd = '{op: op, x_line_addr: n[4:3], y_line_addr: n[2:0], data: d};
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
         if (rd_valid === 1'b1) begin
            got = rd_data;
            check("read valid cycle", 32'(k), 32'h6);
         end
         if (k > 20) begin
            bad_count++;
            $display("[ERR] ready expected 1 seen %b", cmd_ready);
            conclude();
         end
      end while (cmd_ready !== 1'b1);
      check("ready latency", 32'(k), 32'(lat));
      case (op)
         xpc_pkg::OP_WRITE: exp1[n] = d;
         xpc_pkg::OP_DIRECT: begin
            exp1[n] = d;
            exp2 = exp1;
         end
         xpc_pkg::OP_COMMIT: exp2 = exp1;
         xpc_pkg::OP_CLEAR: begin
            exp1 = '0;
            exp2 = '0;
         end
         default: check("read data", {31'h0, got}, {31'h0, exp2[n]});
      endcase
      check("first stage", i_xpc_dev_model.s1_r, exp1);
      check("switch nodes", nodes, exp2);
      check("idle pins", 32'(pins), 32'(xpc_pkg::PINS_IDLE));
   endtask

   // Idle bus after reset, then a clear from unknown power-up state.
   task automatic t_reset();
      check("ready after reset", {31'h0, cmd_ready}, 32'h1);
      check("reset pins", 32'(pins), 32'(xpc_pkg::PINS_IDLE));
      send(xpc_pkg::OP_CLEAR, 5'h0, 1'b0);
      $display("test reset done");
   endtask

   // Staged writes to every node must not move the matrix until the commit.
   task automatic t_batch();
      for (int n = 0; n < 32; n++) send(xpc_pkg::OP_WRITE, 5'(n), n % 3 == 0);
      send(xpc_pkg::OP_WRITE, 5'h1f, 1'b1);
      send(xpc_pkg::OP_COMMIT, 5'h0, 1'b0);
      for (int n = 0; n < 32; n++) send(xpc_pkg::OP_READ, 5'(n), 1'b0);
      $display("test batch done");
   endtask

   // Direct updates also carry any staged write along with them.
   task automatic t_direct();
      send(xpc_pkg::OP_DIRECT, 5'h05, 1'b1);
      send(xpc_pkg::OP_DIRECT, 5'h00, 1'b0);
      send(xpc_pkg::OP_WRITE, 5'h07, 1'b1);
      send(xpc_pkg::OP_DIRECT, 5'h09, 1'b1);
      send(xpc_pkg::OP_READ, 5'h07, 1'b0);
      $display("test direct done");
   endtask

   // A clear opens every node; nodes 5 and 31 are read back afterwards.
   task automatic t_clear();
      send(xpc_pkg::OP_CLEAR, 5'h1f, 1'b1);
      send(xpc_pkg::OP_READ, 5'h05, 1'b0);
      send(xpc_pkg::OP_READ, 5'h1f, 1'b0);
      $display("test clear done");
   endtask

   // Main sequence.
   initial begin
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      exp1 = '0;
      exp2 = '0;
      bad_count = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      t_reset();
      t_batch();
      t_direct();
      t_clear();
      conclude();
   end
endmodule // tb_xpc_host
